// ### include/sci_pkg.sv
// Purpose: Constants, register map and state codes of the card serial engine.
// Assumes: One 200 MHz clock; synchronous active-high reset.
// Notes: Registers are 32-bit words on a plain strobe port.
// Overview of operation
// - Card framing is active only while the frame format select field holds 0x07.
// - Receive and transmit inversion must both be one, so data levels on the line are inverted; card_mode does not check them.
// - Transmit and receive pad select must name the same pin, giving one shared data line.
// - Card framing needs even parity (parity select 0) and 8-bit characters (width 0).
// - Timing select 1 picks T=0 with synchronous transfer and error signalling, 0 picks T=1.
// - A T=0 character is a start bit, eight data bits, a parity bit and two guard bits.
// - The transmitter shifts out start, data and parity, then releases the line for the guard.
// - The guard is lengthened by the number of bits in the extra guard bits field.
// - A clean character leaves the line alone in the guard, and the next one may follow.
// - On a T=0 parity error the receiver pulls the line low in the guard as a NACK.
// - A NACKed character lasts one extra bit: the error bit, then the full guard.
// - A receive parity error sets the parity fault flag and drops the character.
// - The data pin carries the card data both ways and the clock pin gives the card clock.
// - In synchronous operation the rate generator is divided by two, chosen by timing select.
// - With timing select 1, bit rate is the reference over two times (divisor plus one); with 0 it is the reference over (divisor plus one).
// - A transmitter that sees the line low in the guard resends the rejected character; with timing select 0 the guard is not watched and nothing is resent.

package sci_pkg;

   localparam int unsigned sci_aw = 8;
   localparam int unsigned sci_dw = 32;

   // ********************************************************
   // Register offsets.
   // ********************************************************
   localparam logic [7:0] sci_off_control_first = 8'h00;
   localparam logic [7:0] sci_off_control_second = 8'h04;
   localparam logic [7:0] sci_off_control_third = 8'h08;
   localparam logic [7:0] sci_off_rate = 8'h0C;
   localparam logic [7:0] sci_off_data = 8'h10;
   localparam logic [7:0] sci_off_status = 8'h14;
   localparam logic [7:0] sci_off_mask = 8'h18;

   // ********************************************************
   // Field positions and values.
   // ********************************************************
   localparam int unsigned sci_fmt_lsb = 0;
   localparam int unsigned sci_fmt_w = 4;
   localparam logic [3:0] sci_fmt_card = 4'h7;
   localparam int unsigned sci_receive_inversion_bit = 4;
   localparam int unsigned sci_transmit_inversion_bit = 5;
   localparam int unsigned sci_txpad_lsb = 8;
   localparam int unsigned sci_rxpad_lsb = 10;
   localparam int unsigned sci_pad_w = 2;
   localparam int unsigned sci_timing_bit = 12;
   localparam int unsigned sci_enable_bit = 16;
   localparam int unsigned sci_par_bit = 0;
   localparam int unsigned sci_width_lsb = 4;
   localparam int unsigned sci_width_w = 3;
   localparam logic sci_par_even = 1'h0;
   localparam logic [2:0] sci_width_8 = 3'h0;
   localparam int unsigned sci_guard_w = 8;
   localparam int unsigned sci_div_w = 16;
   localparam int unsigned sci_cnt_w = 18;

   // Status and mask bit positions.
   localparam int unsigned sci_st_w = 4;
   localparam int unsigned sci_st_parity_fault_flag = 0;
   localparam int unsigned sci_st_rx = 1;
   localparam int unsigned sci_st_tx = 2;
   localparam int unsigned sci_st_nack = 3;

   // Frame layout: start, eight data, parity.
   localparam logic [3:0] sci_frame_last = 4'h9;
   localparam logic [3:0] sci_parity_idx = 4'h9;
   localparam logic [8:0] sci_guard_min = 9'h002;
   localparam logic [8:0] sci_nack_bits = 9'h001;

   typedef enum logic [2:0] {
      sci_idle_s = 3'h0,
      sci_tx_s = 3'h1,
      sci_txg_s = 3'h2,
      sci_rx_s = 3'h3,
      sci_nack_s = 3'h4,
      sci_guard_s = 3'h5
   } sci_state_t;

endpackage

// ### src/sci_core.sv
// Purpose: Card mode serial engine with register port, card clock and shared data line.
// Assumes: Data pin is driven only while its output enable is low.
// Notes: Single-word receive holding register; a new character overwrites an unread one.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module sci_core (
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic card_clk,
   input wire logic data_in,
   output logic data_out,
   output logic data_oe_n,
   output logic irq
);

   // ********************************************************
   // Register state.
   // ********************************************************
   logic [31:0] control_first_ff;
   logic [31:0] control_second_ff;
   logic [sci_pkg::sci_guard_w-1:0] extra_guard_bits_ff;
   logic [sci_pkg::sci_div_w-1:0] rate_div_ff;
   logic [sci_pkg::sci_st_w-1:0] status_ff;
   logic [sci_pkg::sci_st_w-1:0] mask_ff;
   logic [7:0] tx_data_ff;
   logic tx_pend_ff;
   logic [7:0] rx_data_ff;
   logic [31:0] reg_rdata_ff;

   // ********************************************************
   // Engine state.
   // ********************************************************
   sci_pkg::sci_state_t state_ff;
   sci_pkg::sci_state_t nxt_state;
   logic [sci_pkg::sci_cnt_w-1:0] cyc_cnt_ff;
   logic [8:0] bit_idx_ff;
   logic [7:0] shift_ff;
   logic par_acc_ff;
   logic nack_ff;
   logic drive_ff;
   logic drive_lvl_ff;
   logic line_m_ff;
   logic line_s_ff;
   logic line_d_ff;
   logic [sci_pkg::sci_div_w-1:0] half_cnt_ff;
   logic card_clk_ff;

   logic receive_inversion;
   logic transmit_inversion;
   logic communication_timing_select;
   logic card_mode;
   logic [sci_pkg::sci_cnt_w-1:0] bit_len;
   logic [sci_pkg::sci_cnt_w-1:0] mid_pt;
   logic [sci_pkg::sci_cnt_w-1:0] bit_last;
   logic bit_end;
   logic bit_mid;
   logic [8:0] guard_len;
   logic rx_start;
   logic rx_bit;
   logic [sci_pkg::sci_st_w-1:0] st_set;
   logic st_rd;

   function automatic logic sel(input logic [7:0] addr, input logic [7:0] off);
      sel = (addr == off);
   endfunction

   assign receive_inversion = control_first_ff[sci_pkg::sci_receive_inversion_bit];
   assign transmit_inversion = control_first_ff[sci_pkg::sci_transmit_inversion_bit];
   assign communication_timing_select = control_first_ff[sci_pkg::sci_timing_bit];

   // ********************************************************
   // Mode qualification.
   // ********************************************************
   assign card_mode = control_first_ff[sci_pkg::sci_enable_bit]
      && (control_first_ff[sci_pkg::sci_fmt_lsb +: sci_pkg::sci_fmt_w]
          == sci_pkg::sci_fmt_card)
      && (control_first_ff[sci_pkg::sci_txpad_lsb +: sci_pkg::sci_pad_w]
          == control_first_ff[sci_pkg::sci_rxpad_lsb +: sci_pkg::sci_pad_w])
      && (control_second_ff[sci_pkg::sci_par_bit] == sci_pkg::sci_par_even)
      && (control_second_ff[sci_pkg::sci_width_lsb +: sci_pkg::sci_width_w]
          == sci_pkg::sci_width_8);

   // ********************************************************
   // Rate generator and card clock.
   // ********************************************************
   // The card clock toggles every divisor+1 cycles, so it never exceeds half the reference.
   always_ff @(posedge clock) begin
      if (srst || !card_mode) begin
         half_cnt_ff <= '0;
         card_clk_ff <= 1'b0;
      end else if (half_cnt_ff == rate_div_ff) begin
         half_cnt_ff <= '0;
         card_clk_ff <= !card_clk_ff;
      end else begin
         half_cnt_ff <= half_cnt_ff + 1'b1;
      end
   end

   assign card_clk = card_clk_ff;

   // The divide-by-two stage is switched in by the timing select alone.
   always_comb begin
      if (communication_timing_select) begin
         bit_len = {1'b0, rate_div_ff, 1'b0} + sci_cnt_two();
      end else begin
         bit_len = {2'b00, rate_div_ff} + 1'b1;
      end
   end

   function automatic logic [sci_pkg::sci_cnt_w-1:0] sci_cnt_two();
      sci_cnt_two = {{(sci_pkg::sci_cnt_w-2){1'b0}}, 2'b10};
   endfunction

   // The sample point sits one cycle early to make up for the synchroniser lag.
   assign bit_last = bit_len - 1'b1;
   assign mid_pt = {1'b0, bit_last[sci_pkg::sci_cnt_w-1:1]};
   assign bit_end = (cyc_cnt_ff == bit_last);
   assign bit_mid = (cyc_cnt_ff == mid_pt);
   assign guard_len = sci_pkg::sci_guard_min + {1'b0, extra_guard_bits_ff};

   // ********************************************************
   // Line synchroniser.
   // ********************************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         line_m_ff <= 1'b1;
         line_s_ff <= 1'b1;
         line_d_ff <= 1'b1;
      end else begin
         line_m_ff <= data_in;
         line_s_ff <= line_m_ff;
         line_d_ff <= line_s_ff;
      end
   end

   assign rx_start = line_d_ff && !line_s_ff;
   assign rx_bit = line_s_ff ^ receive_inversion;

   // ********************************************************
   // Character state machine.
   // ********************************************************
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         sci_pkg::sci_idle_s: begin
            if (!card_mode) begin
               nxt_state = sci_pkg::sci_idle_s;
            end else if (rx_start) begin
               nxt_state = sci_pkg::sci_rx_s;
            end else if (tx_pend_ff) begin
               nxt_state = sci_pkg::sci_tx_s;
            end
         end
         sci_pkg::sci_tx_s: begin
            if (bit_end && bit_idx_ff[3:0] == sci_pkg::sci_frame_last) begin
               nxt_state = sci_pkg::sci_txg_s;
            end
         end
         sci_pkg::sci_txg_s: begin
            if (bit_end && bit_idx_ff == guard_len + {8'h00, nack_ff} - 1'b1) begin
               nxt_state = sci_pkg::sci_idle_s;
            end
         end
         sci_pkg::sci_rx_s: begin
            if (bit_end && bit_idx_ff[3:0] == sci_pkg::sci_frame_last) begin
               if (par_acc_ff && communication_timing_select) begin
                  nxt_state = sci_pkg::sci_nack_s;
               end else begin
                  nxt_state = sci_pkg::sci_guard_s;
               end
            end
         end
         sci_pkg::sci_nack_s: begin
            if (bit_end) begin
               nxt_state = sci_pkg::sci_guard_s;
            end
         end
         sci_pkg::sci_guard_s: begin
            if (bit_end && bit_idx_ff == guard_len - 1'b1) begin
               nxt_state = sci_pkg::sci_idle_s;
            end
         end
         default: begin
            nxt_state = sci_pkg::sci_idle_s;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst || !card_mode) begin
         state_ff <= sci_pkg::sci_idle_s;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Cycle counter within a bit and bit index within a phase.
   always_ff @(posedge clock) begin
      if (srst || state_ff == sci_pkg::sci_idle_s || nxt_state != state_ff) begin
         cyc_cnt_ff <= '0;
      end else if (bit_end) begin
         cyc_cnt_ff <= '0;
      end else begin
         cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || nxt_state != state_ff) begin
         bit_idx_ff <= '0;
      end else if (bit_end) begin
         bit_idx_ff <= bit_idx_ff + 1'b1;
      end
   end

   // ********************************************************
   // Receive shifter and parity.
   // ********************************************************
   always_ff @(posedge clock) begin
      if (srst || state_ff == sci_pkg::sci_idle_s) begin
         shift_ff <= '0;
         par_acc_ff <= 1'b0;
      end else if (state_ff == sci_pkg::sci_rx_s && bit_mid && bit_idx_ff[3:0] != 4'h0) begin
         // The parity bit is folded in as well, so a clean character leaves zero.
         par_acc_ff <= par_acc_ff ^ rx_bit;
         if (bit_idx_ff[3:0] != sci_pkg::sci_parity_idx) begin
            shift_ff <= {rx_bit, shift_ff[7:1]};
         end
      end
   end

   // A clean character is kept at the end of its parity bit; a bad one is dropped.
   always_ff @(posedge clock) begin
      if (srst) begin
         rx_data_ff <= '0;
      end else if (state_ff == sci_pkg::sci_rx_s && bit_end
                   && bit_idx_ff[3:0] == sci_pkg::sci_frame_last && !par_acc_ff) begin
         rx_data_ff <= shift_ff;
      end
   end

   // ********************************************************
   // Transmit side and NACK detection.
   // ********************************************************
   always_ff @(posedge clock) begin
      if (srst || state_ff == sci_pkg::sci_idle_s) begin
         nack_ff <= 1'b0;
      // The synchronised line lags two cycles, so the look opens as the first guard bit ends.
      end else if (state_ff == sci_pkg::sci_txg_s && (bit_end || bit_idx_ff != 9'h000)
                   && communication_timing_select && !line_s_ff) begin
         nack_ff <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         drive_ff <= 1'b0;
         drive_lvl_ff <= 1'b1;
      end else begin
         case (nxt_state)
            sci_pkg::sci_tx_s: begin
               drive_ff <= 1'b1;
               if (nxt_state != state_ff) begin
                  drive_lvl_ff <= 1'b0;
               end else if (bit_end && bit_idx_ff[3:0] == 4'h8) begin
                  drive_lvl_ff <= (^tx_data_ff) ^ transmit_inversion;
               end else if (bit_end) begin
                  drive_lvl_ff <= tx_data_ff[bit_idx_ff[2:0]] ^ transmit_inversion;
               end
            end
            sci_pkg::sci_nack_s: begin
               drive_ff <= 1'b1;
               drive_lvl_ff <= 1'b0;
            end
            default: begin
               drive_ff <= 1'b0;
               drive_lvl_ff <= 1'b1;
            end
         endcase
      end
   end

   assign data_out = drive_lvl_ff;
   assign data_oe_n = !drive_ff;

   // The pending character stays armed after a NACK and is sent again.
   always_ff @(posedge clock) begin
      if (srst) begin
         tx_pend_ff <= 1'b0;
         tx_data_ff <= '0;
      end else if (reg_wr && sel(reg_addr, sci_pkg::sci_off_data) && !tx_pend_ff) begin
         tx_pend_ff <= 1'b1;
         tx_data_ff <= reg_wdata[7:0];
      end else if (state_ff == sci_pkg::sci_txg_s && nxt_state == sci_pkg::sci_idle_s) begin
         tx_pend_ff <= nack_ff;
      end else if (!card_mode) begin
         tx_pend_ff <= 1'b0;
      end
   end

   // ********************************************************
   // Status, mask and interrupt.
   // ********************************************************
   always_comb begin
      st_set = '0;
      if (state_ff == sci_pkg::sci_rx_s && bit_end
          && bit_idx_ff[3:0] == sci_pkg::sci_frame_last) begin
         st_set[sci_pkg::sci_st_parity_fault_flag] = par_acc_ff;
         st_set[sci_pkg::sci_st_rx] = !par_acc_ff;
      end
      if (state_ff == sci_pkg::sci_txg_s && nxt_state == sci_pkg::sci_idle_s) begin
         st_set[sci_pkg::sci_st_tx] = !nack_ff;
         st_set[sci_pkg::sci_st_nack] = nack_ff;
      end
   end

   assign st_rd = reg_rd && sel(reg_addr, sci_pkg::sci_off_status);

   // A read clears the flags, but an event in the same cycle still lands.
   always_ff @(posedge clock) begin
      if (srst) begin
         status_ff <= '0;
      end else if (st_rd) begin
         status_ff <= st_set;
      end else begin
         status_ff <= status_ff | st_set;
      end
   end

   assign irq = |(status_ff & mask_ff);

   // ********************************************************
   // Register writes.
   // ********************************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         control_first_ff <= '0;
         control_second_ff <= '0;
         extra_guard_bits_ff <= '0;
         rate_div_ff <= '0;
         mask_ff <= '0;
      end else if (reg_wr) begin
         if (sel(reg_addr, sci_pkg::sci_off_control_first)) begin
            control_first_ff <= reg_wdata;
         end else if (sel(reg_addr, sci_pkg::sci_off_control_second)) begin
            control_second_ff <= reg_wdata;
         end else if (sel(reg_addr, sci_pkg::sci_off_control_third)) begin
            extra_guard_bits_ff <= reg_wdata[sci_pkg::sci_guard_w-1:0];
         end else if (sel(reg_addr, sci_pkg::sci_off_rate)) begin
            rate_div_ff <= reg_wdata[sci_pkg::sci_div_w-1:0];
         end else if (sel(reg_addr, sci_pkg::sci_off_mask)) begin
            mask_ff <= reg_wdata[sci_pkg::sci_st_w-1:0];
         end
      end
   end

   // ********************************************************
   // Register reads, answered one cycle after the strobe.
   // ********************************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rdata_ff <= '0;
      end else if (reg_rd) begin
         if (sel(reg_addr, sci_pkg::sci_off_control_first)) begin
            reg_rdata_ff <= control_first_ff;
         end else if (sel(reg_addr, sci_pkg::sci_off_control_second)) begin
            reg_rdata_ff <= control_second_ff;
         end else if (sel(reg_addr, sci_pkg::sci_off_control_third)) begin
            reg_rdata_ff <= {24'h000000, extra_guard_bits_ff};
         end else if (sel(reg_addr, sci_pkg::sci_off_rate)) begin
            reg_rdata_ff <= {16'h0000, rate_div_ff};
         end else if (sel(reg_addr, sci_pkg::sci_off_data)) begin
            reg_rdata_ff <= {23'h000000, tx_pend_ff, rx_data_ff};
         end else if (sel(reg_addr, sci_pkg::sci_off_status)) begin
            reg_rdata_ff <= {28'h0000000, status_ff};
         end else if (sel(reg_addr, sci_pkg::sci_off_mask)) begin
            reg_rdata_ff <= {28'h0000000, mask_ff};
         end else begin
            reg_rdata_ff <= '0;
         end
      end else begin
         reg_rdata_ff <= '0;
      end
   end

   assign reg_rdata = reg_rdata_ff;

endmodule

`default_nettype wire

// ### test/sci_core_properties.sv
// Purpose: Port-level checks of the card serial engine.
// Assumes: Bound to every instance of the engine.
// Notes: Register offsets come from the shared package.
`timescale 1ns/10ps
`default_nettype none
module sci_props (
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic card_clk,
   input wire logic data_in,
   input wire logic data_out,
   input wire logic data_oe_n,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // ********************************
   // Sequences and assertions.
   // ********************************
   sequence quiet6;
      !reg_wr [*6];
   endsequence
   sequence mask_wr_rd;
      reg_wr && reg_addr == sci_pkg::sci_off_mask ##2 reg_rd && reg_addr == sci_pkg::sci_off_mask;
   endsequence
   AST_RESET_IDLE: assert property (disable iff (1'b0) srst |=>
      data_oe_n && !card_clk && !irq)
      else $error("outputs not idle after reset");
   AST_START_LOW: assert property ($fell(data_oe_n) |-> !data_out)
      else $error("drive did not open with a low level");
   AST_GUARD_FREE: assert property ($rose(data_oe_n) |-> data_oe_n [*2])
      else $error("line driven again inside the guard");
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h18 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_MASK_BACK: assert property (mask_wr_rd |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 3))
      else $error("mask readback wrong");
   AST_FMT_IDLE: assert property (reg_wr && reg_addr == sci_pkg::sci_off_control_first
      && reg_wdata[3:0] != 4'h7 ##1 quiet6 |-> !card_clk && data_oe_n)
      else $error("engine active with other frame format");
   AST_PAD_IDLE: assert property (reg_wr && reg_addr == sci_pkg::sci_off_control_first
      && reg_wdata[9:8] != reg_wdata[11:10] ##1 quiet6 |-> !card_clk && data_oe_n)
      else $error("engine active with split pads");
   AST_PAR_IDLE: assert property (reg_wr && reg_addr == sci_pkg::sci_off_control_second
      && (reg_wdata[0] || reg_wdata[6:4] != 3'h0) ##1 quiet6 |-> !card_clk)
      else $error("engine active with odd parity or short width");
endmodule
bind sci_core sci_props u_props (
   .clock(clock),
   .srst(srst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .card_clk(card_clk),
   .data_in(data_in),
   .data_out(data_out),
   .data_oe_n(data_oe_n),
   .irq(irq)
);
`default_nettype wire

// ### test/sci_card.sv
// Purpose: Behavioural card on the shared data line.
// Assumes: Line has a pull-up; the card only pulls low or releases.
// Notes: Bit length in clocks is set by the bench.
`timescale 1ns/10ps
`default_nettype none
module sci_card (
   input wire logic clock,
   input wire logic line,
   output logic drv_n
);
   int bl = 4;
   int nack_req = 0;
   bit sending = 0;
   bit seen = 0;
   logic [7:0] rxq[$];
   logic prev = 1'b1;
   initial drv_n = 1'b1;
   // ********************************
   // Transmit side.
   // ********************************
   task automatic bit_out(input logic v);
      drv_n <= v;
      repeat (bl) @(posedge clock);
   endtask
   // Sends one character, then looks for a NACK in the middle of the second guard bit.
   task automatic send(input logic [7:0] b, input logic bad);
      sending = 1;
      @(posedge clock);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(~b[i]);
      bit_out(~(^b ^ bad));
      drv_n <= 1'b1;
      repeat (bl + bl / 2) @(posedge clock);
      seen = !line;
      repeat (3 * bl) @(posedge clock);
      sending = 0;
   endtask
   // ********************************
   // Receive side.
   // ********************************
   initial begin : rx
      logic [8:0] s;
      logic [7:0] b;
      forever begin
         @(posedge clock);
         if (!sending && prev && !line) begin
            repeat (bl / 2) @(posedge clock);
            for (int i = 0; i < 9; i++) begin
               repeat (bl) @(posedge clock);
               s[i] = line;
            end
            b = ~s[7:0];
            if (nack_req > 0) begin
               nack_req--;
               repeat (bl / 2) @(posedge clock);
               drv_n <= 1'b0;
               repeat (bl) @(posedge clock);
               drv_n <= 1'b1;
            end else if ((^b) == ~s[8]) begin
               rxq.push_back(b);
            end
         end
         prev = line;
      end
   end
endmodule
`default_nettype wire

// ### test/tb_sci_core.sv
// Purpose: Self-checking bench of the card serial engine.
// Assumes: Card model on the far side of the data line.
// Notes: Rate divisor 1 gives four clocks a bit in T=0.
`timescale 1ns/10ps
`default_nettype none
module tb_sci_core;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic card_clk, data_out, data_oe_n, irq, card_n;
   wire logic line = (data_oe_n | data_out) & card_n;
   int errors = 0;
   int checked = 0;
   int n;
   logic [31:0] acc, d;
   always #2.5 clock = ~clock;
   sci_core dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_clk(card_clk),
      .data_in(line), .data_out(data_out), .data_oe_n(data_oe_n), .irq(irq));
   sci_card card (.clock(clock), .line(line), .drv_n(card_n));
   // ********************************
   // Tasks.
   // ********************************
   task automatic results;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clock);
   endtask
   task automatic poll(input logic [31:0] m);
      for (int i = 0; i < 600 && (acc & m) == 0; i++) begin
         rd(sci_pkg::sci_off_status, d);
         acc = acc | d;
      end
      if ((acc & m) == 0) begin
         errors++;
         results();
      end
   endtask
   task automatic waitq(input int k);
      for (int i = 0; i < 3000 && card.rxq.size() < k; i++) @(posedge clock);
      if (card.rxq.size() < k) begin
         errors++;
         results();
      end
   endtask
   task automatic cfg(input logic t0);
      wr(sci_pkg::sci_off_rate, 32'h1);
      wr(sci_pkg::sci_off_control_second, 32'h0);
      wr(sci_pkg::sci_off_control_third, 32'h0);
      wr(sci_pkg::sci_off_control_first, {19'h8, t0, 12'h037});
      card.bl = t0 ? 4 : 2;
   endtask
   // ********************************
   // Tests.
   // ********************************
   initial begin
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd(sci_pkg::sci_off_status, d);
      chk(d, 32'h0);
      cfg(1'b1);
      wr(sci_pkg::sci_off_mask, 32'hF);
      rd(sci_pkg::sci_off_mask, d);
      chk(d & 32'hF, 32'hF);
      acc = 0;
      wr(sci_pkg::sci_off_data, 32'hA5);
      poll(32'h4);
      wr(sci_pkg::sci_off_data, 32'h3C);
      rd(sci_pkg::sci_off_data, d);
      chk(d & 32'h100, 32'h100);
      wr(sci_pkg::sci_off_data, 32'hFF);
      waitq(2);
      acc = 0;
      poll(32'h4);
      chk(32'(card.rxq.size()), 32'h2);
      chk({24'h0, card.rxq[0]}, 32'hA5);
      chk({24'h0, card.rxq[1]}, 32'h3C);
      $display("transmit test done");
      card.nack_req = 1;
      acc = 0;
      wr(sci_pkg::sci_off_data, 32'h81);
      waitq(3);
      poll(32'h4);
      chk({24'h0, card.rxq[2]}, 32'h81);
      chk(acc & 32'h8, 32'h8);
      $display("nack test done");
      acc = 0;
      card.send(8'h3C, 1'b0);
      poll(32'h2);
      rd(sci_pkg::sci_off_data, d);
      chk(d & 32'hFF, 32'h3C);
      wr(sci_pkg::sci_off_mask, 32'h1);
      card.send(8'h55, 1'b1);
      chk({31'h0, card.seen}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd(sci_pkg::sci_off_status, d);
      chk(d & 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rd(sci_pkg::sci_off_data, d);
      chk(d & 32'hFF, 32'h3C);
      wr(sci_pkg::sci_off_mask, 32'h0);
      card.send(8'h55, 1'b1);
      chk({31'h0, irq}, 32'h0);
      rd(sci_pkg::sci_off_status, d);
      chk(d & 32'h1, 32'h1);
      $display("receive test done");
      cfg(1'b0);
      card.send(8'h66, 1'b1);
      chk({31'h0, card.seen}, 32'h0);
      rd(sci_pkg::sci_off_status, d);
      chk(d & 32'h1, 32'h1);
      card.send(8'h99, 1'b0);
      rd(sci_pkg::sci_off_data, d);
      chk(d & 32'hFF, 32'h99);
      wr(sci_pkg::sci_off_data, 32'h42);
      waitq(4);
      chk({24'h0, card.rxq[3]}, 32'h42);
      for (int k = 0; k < 2; k++) begin
         d = card_clk;
         for (n = 0; n < 50 && card_clk === d[0]; n++) @(posedge clock);
      end
      chk(32'(n), 32'h2);
      $display("block mode test done");
      rd(8'h1C, d);
      chk(d, 32'h0);
      wr(sci_pkg::sci_off_control_first, 32'h0001_1036);
      repeat (8) @(posedge clock);
      chk({31'h0, card_clk}, 32'h0);
      cfg(1'b1);
      wr(sci_pkg::sci_off_control_first, 32'h0001_1137);
      repeat (8) @(posedge clock);
      chk({31'h0, card_clk}, 32'h0);
      cfg(1'b1);
      wr(sci_pkg::sci_off_control_second, 32'h1);
      repeat (8) @(posedge clock);
      chk({31'h0, card_clk}, 32'h0);
      $display("mode select test done");
      results();
   end
endmodule
`default_nettype wire
